// ===== rtl/blc_pkg.sv
package blc_pkg;
    localparam int DW = 32;
    localparam int AW = 32;
    localparam int LOW_W = 24;
    localparam int CMD_LSB = 24;
    localparam int IRQ_W = 6;
    localparam int NGEN = 31;
    localparam logic [AW-1:0] CTRL_ADDR = 32'h4000_0000;
    localparam logic [AW-1:0] IST_ADDR = 32'h4000_0300;
    localparam logic [AW-1:0] IMSK_ADDR = 32'h4000_0304;
    localparam logic [AW-1:0] IACK_ADDR = 32'h4000_0308;
    localparam logic [AW-1:0] GEN_ADDR [NGEN] = '{
        32'h4000_0074, 32'h4000_0080, 32'h4000_0090, 32'h4000_00A0,
        32'h4000_00A4, 32'h4000_00B0, 32'h4000_00B4, 32'h4000_00B8,
        32'h4000_00C0, 32'h4000_00C4, 32'h4000_00C8, 32'h4000_00CC,
        32'h4000_00D0, 32'h4000_00D4, 32'h4000_00D8, 32'h4000_00DC,
        32'h4000_00E0, 32'h4000_00E4, 32'h4000_00E8, 32'h4000_00F0,
        32'h4000_00F4, 32'h4000_00F8, 32'h4000_00FC, 32'h4000_0100,
        32'h4000_0104, 32'h4000_0108, 32'h4000_010C, 32'h4000_0200,
        32'h4000_0208, 32'h4000_020C, 32'h4000_0210};
    localparam logic [DW-1:0] GEN_RST = 32'h0000_0000;

    // Command byte, bit 31 down to bit 24; bit 27 is reserved.
    typedef struct packed {
        logic core_rst;
        logic tg_rst;
        logic reg_rst;
        logic swint;
        logic rsvd;
        logic rft;
        logic adv;
        logic scan;
    } blc_cmd_s;

    // Interrupt status and mask layout, bit 5 down to bit 0.
    typedef struct packed {
        logic scan;
        logic adv;
        logic rft;
        logic tg;
        logic core;
        logic swint;
    } blc_irq_s;

    typedef struct packed {
        logic core;
        logic tg;
        logic adv;
        logic scan;
    } blc_act_s;

    typedef struct packed {
        logic tx_inf;
        logic rx_inf;
        logic byte_end;
        logic crc_end;
        logic aa_det;
        logic pkt_end;
    } blc_rft_s;

    typedef struct packed {
        logic stop;
        logic rf_off;
        logic crc_go;
    } blc_pc_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_TXB = 3'b001,
        ST_TXC = 3'b010,
        ST_RXP = 3'b011,
        ST_FIN = 3'b100
    } blc_abort_e;
endpackage : blc_pkg

// ===== rtl/blc_core_cmd.sv
// Notes on behaviour
// - A one at bit 31 resets the core except registers and timing.
// - A one at bit 30 resets the timing generator only, then clears.
// - A one at bit 29 resets the register block, then clears.
// - The register block reset leaves interrupt status untouched.
// - A one at bit 28 raises the software interrupt when unmasked.
// - A one at bit 26 aborts the running RF test, then clears.
// - Endless transmit abort finishes the byte, then the CRC, then stops.
// - Endless receive abort waits packet end if address seen, else stops.
// - A one at bit 25 aborts the advertising event, then clears.
// - A one at bit 24 aborts the scan window, then clears.
//
// Decided for this implementation: the plain strobed port.
module blc_core_cmd
    import blc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DW-1:0] bus_rdata,
    output blc_act_s act_req,
    input wire blc_act_s act_done,
    input wire blc_rft_s rft_in,
    output blc_pc_s pc_out,
    output logic [LOW_W-1:0] ctrl_low,
    output logic core_software_interrupt,
    output logic irq
);
    logic rst_meta_q;
    logic rst_sync_n_q;
    blc_cmd_s cmd_q;
    blc_cmd_s wcmd;
    blc_irq_s ist_q;
    blc_irq_s imsk_q;
    blc_irq_s w1c;
    blc_abort_e st_q;
    blc_abort_e st_d;
    blc_pc_s pc_q;
    logic [LOW_W-1:0] low_q;
    logic [DW-1:0] gen_q [NGEN];
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rmux;
    logic irq_q;
    logic swirq_q;
    logic wr_ctrl;
    logic wr_ist;
    logic wr_iack;
    logic wr_imsk;
    logic reg_clr;

    // Two stages only; the first feeds nothing but the second.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    assign wr_ctrl = bus_wr && (bus_addr == CTRL_ADDR);
    assign wr_ist = bus_wr && (bus_addr == IST_ADDR);
    assign wr_iack = bus_wr && (bus_addr == IACK_ADDR);
    assign wr_imsk = bus_wr && (bus_addr == IMSK_ADDR);
    assign wcmd = blc_cmd_s'(bus_wdata[DW-1:CMD_LSB]);
    // The register block reset fires in the same cycle its bit is set.
    assign reg_clr = cmd_q.reg_rst;

    // Each command bit is its own flop: only a written one sets it, its own
    // completion clears it, and a new write wins over a completion.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.core_rst <= 1'b0;
        end else if (wr_ctrl && wcmd.core_rst) begin
            cmd_q.core_rst <= 1'b1;
        end else if (act_done.core) begin
            cmd_q.core_rst <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.tg_rst <= 1'b0;
        end else if (wr_ctrl && wcmd.tg_rst) begin
            cmd_q.tg_rst <= 1'b1;
        end else if (act_done.tg) begin
            cmd_q.tg_rst <= 1'b0;
        end
    end

    // The register block reset lasts one cycle, so its bit clears itself
    // the cycle after it is set.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.reg_rst <= 1'b0;
        end else if (wr_ctrl && wcmd.reg_rst) begin
            cmd_q.reg_rst <= 1'b1;
        end else if (cmd_q.reg_rst) begin
            cmd_q.reg_rst <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.swint <= 1'b0;
        end else if (wr_ctrl && wcmd.swint) begin
            cmd_q.swint <= 1'b1;
        end else if (cmd_q.swint) begin
            cmd_q.swint <= 1'b0;
        end
    end

    // Bit 27 has no function and always reads back as zero.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.rsvd <= 1'b0;
        end else begin
            cmd_q.rsvd <= 1'b0;
        end
    end

    // The abort bit clears only when the sequencer reaches its final state.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.rft <= 1'b0;
        end else if (wr_ctrl && wcmd.rft) begin
            cmd_q.rft <= 1'b1;
        end else if (st_q == ST_FIN) begin
            cmd_q.rft <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.adv <= 1'b0;
        end else if (wr_ctrl && wcmd.adv) begin
            cmd_q.adv <= 1'b1;
        end else if (act_done.adv) begin
            cmd_q.adv <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            cmd_q.scan <= 1'b0;
        end else if (wr_ctrl && wcmd.scan) begin
            cmd_q.scan <= 1'b1;
        end else if (act_done.scan) begin
            cmd_q.scan <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            low_q <= '0;
        end else if (reg_clr) begin
            low_q <= '0;
        end else if (wr_ctrl) begin
            low_q <= bus_wdata[LOW_W-1:0];
        end
    end

    generate
        for (genvar i = 0; i < NGEN; i++) begin : g_reg
            always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
                if (!rst_sync_n_q) begin
                    gen_q[i] <= GEN_RST;
                end else if (reg_clr) begin
                    gen_q[i] <= GEN_RST;
                end else if (bus_wr && (bus_addr == GEN_ADDR[i])) begin
                    gen_q[i] <= bus_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            imsk_q <= '0;
        end else if (reg_clr) begin
            imsk_q <= '0;
        end else if (wr_imsk) begin
            imsk_q <= blc_irq_s'(bus_wdata[IRQ_W-1:0]);
        end
    end

    always_comb begin
        w1c = '0;
        if (wr_ist || wr_iack) begin
            w1c = blc_irq_s'(bus_wdata[IRQ_W-1:0]);
        end
    end

    // Each status bit is set by the moment its command completes and the
    // event wins over a clear in the same cycle, so none is ever lost.
    // Status is deliberately outside the register block reset, so a
    // pending event survives it until software acknowledges it.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.swint <= 1'b0;
        end else if (cmd_q.swint) begin
            ist_q.swint <= 1'b1;
        end else if (w1c.swint) begin
            ist_q.swint <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.core <= 1'b0;
        end else if (cmd_q.core_rst && act_done.core) begin
            ist_q.core <= 1'b1;
        end else if (w1c.core) begin
            ist_q.core <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.tg <= 1'b0;
        end else if (cmd_q.tg_rst && act_done.tg) begin
            ist_q.tg <= 1'b1;
        end else if (w1c.tg) begin
            ist_q.tg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.rft <= 1'b0;
        end else if (st_q == ST_FIN) begin
            ist_q.rft <= 1'b1;
        end else if (w1c.rft) begin
            ist_q.rft <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.adv <= 1'b0;
        end else if (cmd_q.adv && act_done.adv) begin
            ist_q.adv <= 1'b1;
        end else if (w1c.adv) begin
            ist_q.adv <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            ist_q.scan <= 1'b0;
        end else if (cmd_q.scan && act_done.scan) begin
            ist_q.scan <= 1'b1;
        end else if (w1c.scan) begin
            ist_q.scan <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(ist_q & imsk_q);
        end
    end

    // The software interrupt has its own output, so it can be routed apart
    // from the summary line; both lag status by one cycle.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            swirq_q <= 1'b0;
        end else begin
            swirq_q <= ist_q.swint && imsk_q.swint;
        end
    end

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (cmd_q.rft) begin
                    if (rft_in.tx_inf) begin
                        st_d = ST_TXB;
                    end else if (rft_in.rx_inf && rft_in.aa_det) begin
                        st_d = ST_RXP;
                    end else begin
                        st_d = ST_FIN;
                    end
                end
            end
            ST_TXB: begin
                if (rft_in.byte_end) begin
                    st_d = ST_TXC;
                end
            end
            ST_TXC: begin
                if (rft_in.crc_end) begin
                    st_d = ST_FIN;
                end
            end
            ST_RXP: begin
                if (rft_in.pkt_end) begin
                    st_d = ST_FIN;
                end
            end
            ST_FIN: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // A receive test with no address seen is cut at once, radio off.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            pc_q <= '0;
        end else begin
            pc_q.stop <= (st_q == ST_FIN);
            pc_q.rf_off <= (st_q == ST_IDLE) && cmd_q.rft &&
                rft_in.rx_inf && !rft_in.tx_inf &&
                !rft_in.aa_det;
            pc_q.crc_go <= (st_d == ST_TXC);
        end
    end

    always_comb begin
        rmux = '0;
        if (bus_addr == CTRL_ADDR) begin
            rmux = {cmd_q, low_q};
        end else if (bus_addr == IST_ADDR) begin
            rmux[IRQ_W-1:0] = ist_q;
        end else if (bus_addr == IMSK_ADDR) begin
            rmux[IRQ_W-1:0] = imsk_q;
        end
        for (int i = 0; i < NGEN; i++) begin
            if (bus_addr == GEN_ADDR[i]) begin
                rmux = gen_q[i];
            end
        end
    end

    // Read data stand for one cycle only; unmapped words read zero.
    always_ff @(posedge sys_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            rdata_q <= '0;
        end else if (bus_rd) begin
            rdata_q <= rmux;
        end else begin
            rdata_q <= '0;
        end
    end

    assign bus_rdata = rdata_q;
    assign act_req.core = cmd_q.core_rst;
    assign act_req.tg = cmd_q.tg_rst;
    assign act_req.adv = cmd_q.adv;
    assign act_req.scan = cmd_q.scan;
    assign pc_out = pc_q;
    assign ctrl_low = low_q;
    assign irq = irq_q;
    assign core_software_interrupt = swirq_q;
endmodule : blc_core_cmd

// ===== sim/blc_core_cmd_assertions.sv
module blc_core_cmd_checker
    import blc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] bus_addr,
    input wire logic [DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [DW-1:0] bus_rdata,
    input wire blc_act_s act_req,
    input wire blc_act_s act_done,
    input wire blc_rft_s rft_in,
    input wire blc_pc_s pc_out,
    input wire logic [LOW_W-1:0] ctrl_low,
    input wire logic core_software_interrupt,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_cmd(int b);
        bus_wr && bus_addr == CTRL_ADDR && bus_wdata[b];
    endsequence
    sequence s_done_core;
        act_req.core && act_done.core && !(bus_wr && bus_addr == CTRL_ADDR);
    endsequence
    a_core_req_set:
        assert property (s_cmd(31) |=> act_req.core) else $error("no core req");
    a_core_req_clr:
        assert property (s_done_core |=> !act_req.core) else $error("core held");
    a_tg_req_set:
        assert property (s_cmd(30) |=> act_req.tg) else $error("no timing req");
    a_adv_req_set:
        assert property (s_cmd(25) |=> act_req.adv) else $error("no adv req");
    a_scan_req_set:
        assert property (s_cmd(24) |=> act_req.scan) else $error("no scan req");
    a_swint_irq:
        assert property (core_software_interrupt |-> irq) else $error("irq low");
    a_rfoff_stop:
        assert property (pc_out.rf_off |=> pc_out.stop) else $error("no stop");
    a_crc_stop:
        assert property ($fell(pc_out.crc_go) |-> ##[0:3] pc_out.stop)
        else $error("no stop after crc");
    a_stop_pulse:
        assert property (pc_out.stop |=> !pc_out.stop) else $error("long stop");
endmodule : blc_core_cmd_checker

bind blc_core_cmd blc_core_cmd_checker chk_u (.sys_clk, .rst_n, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .act_req, .act_done, .rft_in,
    .pc_out, .ctrl_low, .core_software_interrupt, .irq);

// ===== sim/blc_core_cmd_bench.sv
module blc_core_cmd_bench
    import blc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [AW-1:0] bus_addr = '0;
    logic [DW-1:0] bus_wdata = '0;
    logic [DW-1:0] bus_rdata;
    blc_act_s act_req;
    blc_act_s act_done = '0;
    blc_rft_s rft_in = '0;
    blc_pc_s pc_out;
    logic [LOW_W-1:0] ctrl_low;
    logic core_software_interrupt;
    logic irq;
    logic off;
    logic crc;
    int n;
    int err_count = 0;
    int checked = 0;

    blc_core_cmd dut_u (.sys_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata, .act_req, .act_done, .rft_in, .pc_out, .ctrl_low,
        .core_software_interrupt, .irq);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task chk(input string what, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, e, seen);
        end
    endtask : chk

    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [31:0] a, input logic [31:0] e, input string what);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        chk(what, bus_rdata, e);
    endtask : rd

    task cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc

    task done(input logic [3:0] d);
        @(posedge sys_clk);
        act_done <= d;
        @(posedge sys_clk);
        act_done <= '0;
        #1;
    endtask : done

    // The far side answers crc_end one cycle late on purpose, as a slow core.
    task abort_run(input logic tx, input logic rx, input logic aa);
        @(posedge sys_clk);
        rft_in <= '{tx_inf: tx, rx_inf: rx, aa_det: aa, default: 1'b0};
        wr(CTRL_ADDR, 32'h0400_0000);
        off = 1'b0;
        crc = 1'b0;
        n = 0;
        while (n < 40 && pc_out.stop !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            rft_in.byte_end <= (n == 4);
            rft_in.pkt_end <= (n == 6);
            rft_in.crc_end <= (pc_out.crc_go === 1'b1);
            #1;
            off = off | pc_out.rf_off;
            crc = crc | pc_out.crc_go;
        end
        chk("stop", 32'(pc_out.stop), 32'h1);
    endtask : abort_run

    task results;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(CTRL_ADDR, 32'h0, "ctrl reset");
        for (int i = 0; i < NGEN; i++) begin
            wr(GEN_ADDR[i], 32'hA5A5_0000 + 32'(i));
        end
        rd(GEN_ADDR[30], 32'hA5A5_001E, "plain reg");
        rd(32'h4000_0004, 32'h0, "unmapped");
        wr(CTRL_ADDR, 32'hC300_0000);
        chk("act all", 32'(act_req), 32'hF);
        rd(CTRL_ADDR, 32'hC300_0000, "pending");
        done(4'h8);
        chk("act core", 32'(act_req), 32'h7);
        done(4'h7);
        chk("act none", 32'(act_req), 32'h0);
        wr(IMSK_ADDR, 32'h0000_0002);
        cyc(2);
        chk("irq core", 32'(irq), 32'h1);
        rd(IST_ADDR, 32'h0000_0036, "status");
        wr(IACK_ADDR, 32'h0000_0036);
        cyc(2);
        chk("irq clr", 32'(irq), 32'h0);
        wr(CTRL_ADDR, 32'h0);
        chk("zero write", 32'(act_req), 32'h0);
        wr(IMSK_ADDR, 32'h0000_0001);
        wr(CTRL_ADDR, 32'h1000_0000);
        cyc(2);
        chk("sw irq", 32'(core_software_interrupt), 32'h1);
        rd(CTRL_ADDR, 32'h0, "swint clr");
        wr(CTRL_ADDR, 32'h0012_3456);
        chk("ctrl low", 32'(ctrl_low), 32'h0012_3456);
        wr(CTRL_ADDR, 32'h2012_3456);
        cyc(2);
        chk("low rst", 32'(ctrl_low), 32'h0);
        rd(GEN_ADDR[0], 32'h0, "reg rst");
        rd(IMSK_ADDR, 32'h0, "mask rst");
        rd(IST_ADDR, 32'h0000_0001, "status kept");
        wr(IACK_ADDR, 32'h0000_0001);
        rd(IST_ADDR, 32'h0, "acked");
        wr(IMSK_ADDR, 32'h0000_0008);
        abort_run(1'b1, 1'b0, 1'b0);
        chk("tx crc", {30'h0, crc, off}, 32'h2);
        chk("tx wait", 32'(n > 5), 32'h1);
        abort_run(1'b0, 1'b1, 1'b1);
        chk("rx aa", {30'h0, crc, off}, 32'h0);
        chk("rx wait", 32'(n > 6), 32'h1);
        abort_run(1'b0, 1'b1, 1'b0);
        chk("rx off", {30'h0, crc, off}, 32'h1);
        rd(IST_ADDR, 32'h0000_0008, "rft status");
        rd(CTRL_ADDR, 32'h0, "abort clr");
        chk("rft irq", 32'(irq), 32'h1);
        wr(IST_ADDR, 32'h0000_0008);
        rd(IST_ADDR, 32'h0, "status w1c");
        chk("irq w1c", 32'(irq), 32'h0);
        results();
    end
endmodule : blc_core_cmd_bench
